/* rtl/cic_executor.sv */
// executor for interrupt return and the two user-variable calculation commands
`timescale 1ns/10ps
module cic_executor import cic_pkg::*; #(
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] HOST_ADDR = 8'h02
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// command frames
	input wire logic cmd_valid,
	input wire logic cmd_direct,
	input wire cic_cmd_type cmd_frame,
	// interrupt entry and context load from the surrounding core
	input wire logic irq_take,
	input wire logic [CIC_PC_WIDTH-1:0] irq_vector,
	input wire logic ctx_wr,
	input wire cic_ctx_type ctx_in,
	// user variable read port
	input wire logic [7:0] var_rd_idx,
	output cic_reply_type reply_frame,
	output logic reply_valid,
	output cic_ctx_type ctx,
	output logic irq_active,
	output logic resumed,
	output logic [31:0] var_rd_data
);
	typedef struct packed {
		logic [CIC_VAR_COUNT-1:0][31:0] vars;
		cic_ctx_type ctx;
		cic_ctx_type saved;
		logic in_irq;
		cic_reply_type reply;
		logic reply_valid;
		logic resumed;
		logic [31:0] rd_data;
	} cic_state_type;

	cic_state_type st;
	cic_state_type next_st;

	logic addr_hit;
	logic sum_ok;
	logic is_return;
	logic is_vv;
	logic is_va;
	logic [7:0] idx_a;
	logic [7:0] idx_b;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [31:0] res;
	logic [31:0] diff;
	logic div_zero;
	logic op_ok;
	cic_op_type op;

	always_comb begin
		addr_hit = cmd_valid && (cmd_frame.target == MODULE_ADDR);
		// program frames carry no meaningful checksum, only host frames are checked
		sum_ok = !cmd_direct || (cic_sum8(cmd_frame[71:8]) == cmd_frame.csum);
		is_return = addr_hit && (cmd_frame.instr == CIC_INSTR_RETURN);
		is_vv = addr_hit && (cmd_frame.instr == CIC_INSTR_VV);
		is_va = addr_hit && (cmd_frame.instr == CIC_INSTR_VA);
		idx_a = cmd_frame.bank;
		idx_b = cmd_frame.value[7:0];
		opa = st.vars[idx_a];
		opb = is_vv ? st.vars[idx_b] : st.ctx.accu;
		op = cic_op_type'(cmd_frame.kind[3:0]);
		op_ok = (cmd_frame.kind <= 8'(CIC_OP_COMP));
		div_zero = (opb == 32'h0000_0000);
		diff = opa - opb;
		case (op)
			CIC_OP_ADD: res = opa + opb;
			CIC_OP_SUB: res = diff;
			CIC_OP_MUL: res = opa * opb;
			CIC_OP_DIV: res = div_zero ? opa : 32'($signed(opa) / $signed(opb));
			CIC_OP_MOD: res = div_zero ? opa : 32'($signed(opa) % $signed(opb));
			CIC_OP_AND: res = opa & opb;
			CIC_OP_OR: res = opa | opb;
			CIC_OP_XOR: res = opa ^ opb;
			CIC_OP_NOT: res = ~opb;
			CIC_OP_LOAD: res = opb;
			CIC_OP_SWAP: res = opb;
			default: res = opa;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.reply_valid = 1'b0;
		next_st.resumed = 1'b0;
		if (ctx_wr) begin
			next_st.ctx = ctx_in;
		end
		if ((is_vv || is_va) && sum_ok && op_ok) begin
			// compare only sets flags; a zero divisor leaves the variable untouched
			if (op != CIC_OP_COMP && !((op == CIC_OP_DIV || op == CIC_OP_MOD) && div_zero)) begin
				next_st.vars[idx_a] = res;
			end
			if (op == CIC_OP_SWAP) begin
				if (is_vv) begin
					next_st.vars[idx_b] = opa;
				end else begin
					next_st.ctx.accu = opa;
				end
			end
			next_st.ctx.flags[CIC_FLAG_ZERO] = (op == CIC_OP_COMP) ? (diff == 32'h0000_0000)
				: (res == 32'h0000_0000);
			next_st.ctx.flags[CIC_FLAG_NEG] = (op == CIC_OP_COMP) ? ($signed(opa) < $signed(opb))
				: res[31];
			next_st.ctx.flags[CIC_FLAG_DIVZ] = (op == CIC_OP_DIV || op == CIC_OP_MOD) && div_zero;
		end
		if (is_return && sum_ok && st.in_irq) begin
			next_st.ctx = st.saved;
			next_st.in_irq = 1'b0;
			next_st.resumed = 1'b1;
		end
		if (irq_take && !next_st.in_irq) begin
			next_st.saved = next_st.ctx;
			next_st.ctx.pc = irq_vector;
			next_st.in_irq = 1'b1;
		end
		if ((is_return || is_vv || is_va) && cmd_direct) begin
			next_st.reply_valid = 1'b1;
			next_st.reply.host = HOST_ADDR;
			next_st.reply.target = MODULE_ADDR;
			next_st.reply.instr = cmd_frame.instr;
			next_st.reply.status = !sum_ok ? CIC_STATUS_BAD_SUM
				: ((is_return || op_ok) ? CIC_STATUS_OK : CIC_STATUS_BAD_TYPE);
			next_st.reply.value = is_return ? 32'h0000_0000 : opb;
			next_st.reply.csum = cic_sum8({next_st.reply.host, next_st.reply.target,
				next_st.reply.status, next_st.reply.instr, next_st.reply.value});
		end
		next_st.rd_data = next_st.vars[var_rd_idx];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.ctx.flags <= CIC_FLAGS_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reply_frame = st.reply;
	assign reply_valid = st.reply_valid;
	assign ctx = st.ctx;
	assign irq_active = st.in_irq;
	assign resumed = st.resumed;
	assign var_rd_data = st.rd_data;

	a_reply_ok_status: assert property (@(posedge clk_sys) disable iff (rst)
		((is_vv || is_va) && cmd_direct && sum_ok && op_ok) |=> reply_valid
		&& reply_frame.status == 8'h64 && reply_frame.value == $past(opb))
		else $error("calculation reply missing or not ok");
	a_return_reply: assert property (@(posedge clk_sys) disable iff (rst)
		(is_return && cmd_direct && sum_ok) |=> reply_valid && reply_frame.status == 8'h64
		&& reply_frame.instr == 8'h26)
		else $error("return reply wrong");
	a_return_restore: assert property (@(posedge clk_sys) disable iff (rst)
		(is_return && sum_ok && irq_active && !irq_take) |=> ctx == $past(st.saved)
		&& !irq_active && resumed)
		else $error("return did not restore context");
	a_vv_keeps_accu: assert property (@(posedge clk_sys) disable iff (rst)
		(is_vv && !ctx_wr && !irq_take && !is_return) |=> ctx.accu == $past(ctx.accu)
		&& ctx.xreg == $past(ctx.xreg))
		else $error("two-variable command touched accumulator");
	a_vv_add_result: assert property (@(posedge clk_sys) disable iff (rst)
		(is_vv && sum_ok && op_ok && op == CIC_OP_ADD) |=>
		st.vars[$past(idx_a)] == $past(st.vars[idx_a] + st.vars[idx_b]))
		else $error("two-variable add result wrong");
	a_va_swap: assert property (@(posedge clk_sys) disable iff (rst)
		(is_va && sum_ok && op_ok && op == CIC_OP_SWAP && !ctx_wr && !irq_take) |=>
		ctx.accu == $past(opa) && st.vars[$past(idx_a)] == $past(st.ctx.accu))
		else $error("accumulator exchange wrong");
	a_bad_sum_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		((is_vv || is_va) && cmd_direct && !sum_ok) |=> reply_frame.status != 8'h64
		&& st.vars == $past(st.vars))
		else $error("bad checksum accepted");
	a_program_silent: assert property (@(posedge clk_sys) disable iff (rst)
		(cmd_valid && !cmd_direct) |=> !reply_valid)
		else $error("reply sent for program command");
	a_irq_vector: assert property (@(posedge clk_sys) disable iff (rst)
		(irq_take && !irq_active && !is_return) |=> irq_active && ctx.pc == $past(irq_vector))
		else $error("interrupt entry wrong");
	a_reply_sum: assert property (@(posedge clk_sys) disable iff (rst)
		reply_valid |-> reply_frame.csum == cic_sum8(reply_frame[71:8])
		&& reply_frame.host == HOST_ADDR)
		else $error("reply checksum wrong");
	a_bad_type_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		((is_vv || is_va) && cmd_direct && sum_ok && !op_ok) |=> reply_valid
		&& reply_frame.status == CIC_STATUS_BAD_TYPE && st.vars == $past(st.vars))
		else $error("unknown operation not refused");
	a_compare_no_write: assert property (@(posedge clk_sys) disable iff (rst)
		((is_vv || is_va) && op_ok && op == CIC_OP_COMP) |=>
		st.vars == $past(st.vars))
		else $error("compare wrote a variable");
	a_va_load_copy: assert property (@(posedge clk_sys) disable iff (rst)
		(is_va && sum_ok && op_ok && op == CIC_OP_LOAD) |=>
		st.vars[$past(idx_a)] == $past(st.ctx.accu))
		else $error("accumulator copy wrong");
	a_vv_swap_pair: assert property (@(posedge clk_sys) disable iff (rst)
		(is_vv && sum_ok && op_ok && op == CIC_OP_SWAP) |=> st.vars[$past(idx_a)]
		== $past(st.vars[idx_b]) && st.vars[$past(idx_b)] == $past(st.vars[idx_a]))
		else $error("two-variable exchange wrong");
	a_return_outside: assert property (@(posedge clk_sys) disable iff (rst)
		(is_return && !irq_active) |=>
		!resumed)
		else $error("return outside a handler resumed");
	a_irq_refused: assert property (@(posedge clk_sys) disable iff (rst)
		(irq_take && irq_active && !is_return) |=> irq_active
		&& st.saved == $past(st.saved))
		else $error("interrupt taken inside a handler");
	a_reply_target: assert property (@(posedge clk_sys) disable iff (rst)
		reply_valid |-> reply_frame.target == MODULE_ADDR
		&& reply_frame.instr == $past(cmd_frame.instr))
		else $error("reply address or echo wrong");
endmodule

/* include/cic_pkg.sv */
// shared types and constants for the calculation and interrupt-return executor
package cic_pkg;
	localparam logic [7:0] CIC_INSTR_RETURN = 8'h26;
	localparam logic [7:0] CIC_INSTR_VV = 8'h28;
	localparam logic [7:0] CIC_INSTR_VA = 8'h29;
	localparam logic [7:0] CIC_STATUS_OK = 8'h64;
	localparam logic [7:0] CIC_STATUS_BAD_SUM = 8'h01;
	localparam logic [7:0] CIC_STATUS_BAD_TYPE = 8'h03;
	localparam int CIC_VAR_COUNT = 256;
	localparam int CIC_PC_WIDTH = 24;
	localparam logic [3:0] CIC_FLAGS_RESET = 4'h0;
	localparam int CIC_FLAG_ZERO = 0;
	localparam int CIC_FLAG_NEG = 1;
	localparam int CIC_FLAG_DIVZ = 2;

	typedef enum logic [3:0] {
		CIC_OP_ADD = 4'h0, CIC_OP_SUB = 4'h1, CIC_OP_MUL = 4'h2, CIC_OP_DIV = 4'h3,
		CIC_OP_MOD = 4'h4, CIC_OP_AND = 4'h5, CIC_OP_OR = 4'h6, CIC_OP_XOR = 4'h7,
		CIC_OP_NOT = 4'h8, CIC_OP_LOAD = 4'h9, CIC_OP_SWAP = 4'ha, CIC_OP_COMP = 4'hb
	} cic_op_type;

	typedef struct packed {
		logic [7:0] target;
		logic [7:0] instr;
		logic [7:0] kind;
		logic [7:0] bank;
		logic [31:0] value;
		logic [7:0] csum;
	} cic_cmd_type;

	typedef struct packed {
		logic [7:0] host;
		logic [7:0] target;
		logic [7:0] status;
		logic [7:0] instr;
		logic [31:0] value;
		logic [7:0] csum;
	} cic_reply_type;

	typedef struct packed {
		logic [31:0] accu;
		logic [31:0] xreg;
		logic [3:0] flags;
		logic [CIC_PC_WIDTH-1:0] pc;
	} cic_ctx_type;

	// modulo-256 sum of the eight leading bytes of a frame
	function automatic logic [7:0] cic_sum8(input logic [63:0] bytes);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + bytes[i*8 +: 8];
		end
		return s;
	endfunction
endpackage

/* bench/cic_host_model.sv */
// host controller model issuing nine-byte command frames
`timescale 1ns/10ps
module cic_host_model import cic_pkg::*; (
	// clock
	input wire logic clk_sys,
	// command frames
	output logic cmd_valid,
	output logic cmd_direct,
	output cic_cmd_type cmd_frame
);
	initial begin
		cmd_valid = 1'b0;
		cmd_direct = 1'b0;
		cmd_frame = '0;
	end
	task automatic send(input logic [7:0] ins, kd, bk, input logic [31:0] val, input logic dir,
		bad);
		logic [7:0] s;
		s = 8'h01 + ins + kd + bk + val[31:24] + val[23:16] + val[15:8] + val[7:0];
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_direct <= dir;
		cmd_frame <= '{8'h01, ins, kd, bk, val, s ^ {7'h00, bad}};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		// released frame shows no stale copy
		cmd_frame <= ~cmd_frame;
	endtask
endmodule

/* bench/tb_top.sv */
// top-level bench for the calculation and interrupt-return executor
`timescale 1ns/10ps
module tb_top import cic_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst, cmd_valid, cmd_direct, irq_take, ctx_wr, reply_valid, irq_active, resumed;
	cic_cmd_type cmd_frame;
	logic [23:0] irq_vector;
	cic_ctx_type ctx_in, ctx;
	logic [7:0] var_rd_idx;
	cic_reply_type reply_frame;
	logic [31:0] var_rd_data;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 clk_sys = ~clk_sys;
	cic_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_direct(cmd_direct),
		.cmd_frame(cmd_frame));
	cic_executor dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_direct(cmd_direct), .cmd_frame(cmd_frame), .irq_take(irq_take),
		.irq_vector(irq_vector), .ctx_wr(ctx_wr), .ctx_in(ctx_in), .var_rd_idx(var_rd_idx),
		.reply_frame(reply_frame), .reply_valid(reply_valid), .ctx(ctx),
		.irq_active(irq_active), .resumed(resumed), .var_rd_data(var_rd_data));
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_frame(input string nm, input logic [71:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic put_ctx(input logic [31:0] a);
		@(posedge clk_sys);
		ctx_wr <= 1'b1;
		ctx_in <= '{a, {a[15:0], a[15:0]}, a[3:0], a[23:0]};
		@(posedge clk_sys);
		ctx_wr <= 1'b0;
	endtask
	// error replies: value field undefined, so only the status is judged
	task automatic cmd(input logic [7:0] ins, kd, bk, input logic [31:0] val, input logic dir,
		bad, input logic [7:0] st, input logic [31:0] rv);
		logic [7:0] s;
		u_host.send(ins, kd, bk, val, dir, bad);
		#1;
		chk_word("reply_valid", {31'h0, dir}, {31'h0, reply_valid});
		s = 8'h03 + st + ins + rv[31:24] + rv[23:16] + rv[15:8] + rv[7:0];
		if (dir && st == CIC_STATUS_OK) begin
			chk_frame("reply", {8'h02, 8'h01, st, ins, rv, s}, reply_frame);
		end else if (dir) begin
			chk_word("status", {24'h0, st}, {24'h0, reply_frame.status});
		end
	endtask
	task automatic rd_var(input logic [7:0] i, input logic [31:0] e);
		@(posedge clk_sys);
		var_rd_idx <= i;
		@(posedge clk_sys);
		#1;
		chk_word("var", e, var_rd_data);
	endtask
	task automatic t_va_ops;
		logic [31:0] exp [12] = '{32'h11, 32'h7, 32'h3c, 32'h2, 32'h2, 32'h4, 32'hd, 32'h9,
			32'hffff_fffa, 32'h5, 32'h5, 32'hc};
		for (int k = 0; k < 12; k++) begin
			put_ctx(32'hc);
			cmd(CIC_INSTR_VA, 8'h09, 8'h07, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'hc);
			put_ctx(32'h5);
			cmd(CIC_INSTR_VA, k[7:0], 8'h07, 32'hdead, 1'b1, 1'b0, CIC_STATUS_OK, 32'h5);
			rd_var(8'h07, exp[k]);
			chk_word("accu", (k == 10) ? 32'hc : 32'h5, ctx.accu);
		end
	endtask
	task automatic t_vv;
		put_ctx(32'h8);
		cmd(CIC_INSTR_VA, 8'h09, 8'hff, 32'h0, 1'b0, 1'b0, CIC_STATUS_OK, 32'h8);
		put_ctx(32'h3);
		cmd(CIC_INSTR_VA, 8'h09, 8'h00, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'h3);
		cmd(CIC_INSTR_VV, 8'h01, 8'hff, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'h3);
		rd_var(8'hff, 32'h5);
		chk_word("accu", 32'h3, ctx.accu);
		chk_word("xreg", 32'h0003_0003, ctx.xreg);
		cmd(CIC_INSTR_VV, 8'h09, 8'h00, 32'hff, 1'b1, 1'b1, CIC_STATUS_BAD_SUM, 32'h0);
		cmd(CIC_INSTR_VV, 8'h0c, 8'h00, 32'hff, 1'b1, 1'b0, CIC_STATUS_BAD_TYPE, 32'h0);
		rd_var(8'h00, 32'h3);
		cmd(CIC_INSTR_VV, 8'h0a, 8'hff, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'h3);
		rd_var(8'hff, 32'h3);
		rd_var(8'h00, 32'h5);
	endtask
	task automatic t_irq;
		put_ctx(32'h1357);
		@(posedge clk_sys);
		irq_take <= 1'b1;
		irq_vector <= 24'h00_0abc;
		@(posedge clk_sys);
		irq_take <= 1'b0;
		#1;
		chk_word("active", 32'h1, {31'h0, irq_active});
		chk_word("pc", 32'habc, {8'h0, ctx.pc});
		// a second request inside the handler must leave the saved copy alone
		@(posedge clk_sys);
		irq_take <= 1'b1;
		irq_vector <= 24'h00_0def;
		@(posedge clk_sys);
		irq_take <= 1'b0;
		#1;
		chk_word("pc", 32'habc, {8'h0, ctx.pc});
		put_ctx(32'h2468);
		cmd(CIC_INSTR_RETURN, 8'hff, 8'h00, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'h0);
		chk_word("resumed", 32'h1, {31'h0, resumed});
		chk_word("active", 32'h0, {31'h0, irq_active});
		chk_word("accu", 32'h1357, ctx.accu);
		chk_word("pc", 32'h1357, {8'h0, ctx.pc});
		chk_word("xreg", 32'h1357_1357, ctx.xreg);
		chk_word("flags", 32'h7, {28'h0, ctx.flags});
		// return with no handler running: ok reply, nothing restored
		cmd(CIC_INSTR_RETURN, 8'hff, 8'h00, 32'h0, 1'b1, 1'b0, CIC_STATUS_OK, 32'h0);
		chk_word("resumed", 32'h0, {31'h0, resumed});
		chk_word("accu", 32'h1357, ctx.accu);
	endtask
	initial begin
		rst = 1'b1;
		irq_take = 1'b0;
		irq_vector = '0;
		ctx_wr = 1'b0;
		ctx_in = '0;
		var_rd_idx = '0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_va_ops;
		t_vv;
		t_irq;
		print_verdict;
	end
	// the scenarios need well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			print_verdict;
		end
	end
endmodule
